// ---- dma_ctrl_defines.svh ----
// Register indices, field positions and reset values of the DMA control block.
// Included by the design; holds definitions only.
`ifndef DMA_CTRL_DEFINES_SVH
`define DMA_CTRL_DEFINES_SVH

// Register indices; the APB byte address is four times the index.
`define IDX_GLOBAL_CONFIG_STATUS  6'h00
`define IDX_GLOBAL_IRQ_SUMMARY    6'h01
`define IDX_CHANNEL_BASE          6'h04
`define IDX_CHANNEL_STRIDE        6'h04
`define SUB_CHANNEL_CONFIG        2'h0
`define SUB_CHANNEL_STATUS        2'h1
`define SUB_CHANNEL_COUNT         2'h2

// Global register fields.
`define GCS_ON_BIT                0
`define GCS_ACTIVE_BIT            1
`define GCS_WAIT_LSB              2
`define GCS_WAIT_MSB              7
`define GCS_RESET                 8'hfc

// Channel configuration fields.
`define CFG_EN_BIT                0
`define CFG_ALL_DONE_IE_BIT       1
`define CFG_HALF_DONE_IE_BIT      2
`define CFG_DIR_BIT               3
`define CFG_WRAP_BIT              4
`define CFG_STEP_UP_BIT           5
`define CFG_MEM_BIT               6
`define CFG_RESET                 8'h00
`define MEM_CHANNEL               2'h3

// Channel status and priority fields.
`define SPR_ALL_DONE_BIT          1
`define SPR_HALF_DONE_BIT         2
`define SPR_WIDE_BIT              3
`define SPR_PRIO_LSB              4
`define SPR_PRIO_MSB              5
`define SPR_WAITING_BIT           6
`define SPR_BUSY_BIT              7
`define SPR_RESET                 8'h00
`define COUNT_RESET               8'h00
`define PRIO_VERY_HIGH            2'h3

`endif

// ---- dma_ctrl_pkg.sv ----
// Types shared by the DMA control block.
// Assumes nothing of its surroundings.
`default_nettype none
package dma_ctrl_pkg;
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_MOVE
	} engine_state_t;
endpackage : dma_ctrl_pkg
`default_nettype wire

// ---- dma_channel_control_status.sv ----
// Control, status and arbitration logic of a four-channel DMA controller.
// Assumes an APB master, peripheral request lines synchronous to clk_sys_i and a bus
// arbiter that grants one item per granted cycle.
// What this block does
// - Half and all done flags, gated by enables, form interrupts; wake only outside halt.
// - Flags clear by writing 0 even while enabled; clear beats a same-cycle set.
// - All done rises when the programmed transaction ends, regardless of peripheral.
// - Idle wait field sets cycles after last request before high-priority bus request.
// - Idle wait zero asks high-priority access immediately after a served request.
// - Idle wait field ignores writes while global on and global active are set.
// - Global active is read-only, the OR of all channel busy flags.
// - Global on zero disables all channels; otherwise each channel enable decides.
// - Summary register bit per channel is set while either channel flag is set.
// - Channel config ignores writes while enabled with global on, or while busy.
// - Memory-to-memory select exists only on channel 3; elsewhere reads zero.
// - Config bit 5 steps memory pointer up or down; peripheral pointer never moves.
// - In memory-to-memory mode source always steps up; destination follows bit 5.
// - Wrap reload restores programmed count at end, never in memory-to-memory mode.
// - Direction bit selects peripheral-to-memory or reverse; ignored in memory mode.
// - Count reaching zero leaves channel enabled; disabling keeps pointers unchanged.
// - Status bit 7 shows busy, bit 6 shows a waiting request.
// - Priority field ranks channels; very high also outranks the CPU.
// - Priority and width bits ignore writes while enabled with global on, or busy.
// - Status bit 3 selects byte or 16-bit items; a 16-bit item moves whole.
// - Count is writable only while disabled; enabled, it shows items remaining.
// - Count stays zero after a non-reloaded end; requests at zero are not served.
`timescale 1ns/1ps
`default_nettype none
`include "dma_ctrl_defines.svh"

module dma_channel_control_status (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic [3:0]  periph_req_i,
	input  wire logic        bus_grant_i,
	input  wire logic        wait_mode_i,
	input  wire logic        halt_mode_i,
	output logic             bus_req_o,
	output logic             bus_high_prio_o,
	output logic             item_done_o,
	output logic      [1:0]  xfer_channel_o,
	output logic             xfer_to_periph_o,
	output logic             xfer_mem_to_mem_o,
	output logic             xfer_wide_o,
	output logic             mem0_step_up_o,
	output logic             mem1_step_up_o,
	output logic      [3:0]  channel_irq_o,
	output logic             wake_req_o
);

	// Register map seen by software, one 8-bit register in the low byte of each word.
	// Index 0 is the global configuration and status register, index 1 the read-only
	// summary. Each channel owns a group of four indices starting at index 4: first its
	// configuration, then its status and priority, then its remaining count. The fourth
	// index of every group is unmapped and answers with a slave error.
	// Protected fields never raise an error; a refused write is simply dropped, so that
	// software may rewrite a whole register while only the free fields change.

	// Reset values of the global fields, split out of the register's reset word.
	localparam logic [7:0] gcs_reset_word  = `GCS_RESET;
	localparam logic       global_on_reset = gcs_reset_word[`GCS_ON_BIT];
	localparam logic [5:0] idle_wait_reset = gcs_reset_word[`GCS_WAIT_MSB:`GCS_WAIT_LSB];

	// Index of the channel that wins among eligible ones; ties go to the lowest number.
	function automatic logic [1:0] pick_channel(input logic [3:0] elig,
	                                            input logic [7:0] prio);
		logic [1:0] best;
		logic [2:0] best_lvl;
		best     = 2'h0;
		best_lvl = 3'h0;
		for (int i = 0; i < 4; i++) begin
			if (elig[i] && ({1'b1, prio[2*i +: 2]} > best_lvl)) begin
				best     = 2'(i);
				best_lvl = {1'b1, prio[2*i +: 2]};
			end
		end
		return best;
	endfunction : pick_channel

	dma_ctrl_pkg::engine_state_t state;
	logic [1:0]  cur;
	logic        global_on;
	logic [5:0]  idle_wait_cycles;
	logic [5:0]  wait_cnt;
	logic [31:0] rdata;
	logic [31:0] next_rdata;

	wire  [3:0]      busy_v;
	wire  [3:0]      eligible_v;
	wire  [3:0]      flag_any_v;
	wire  [3:0][7:0] cfg_v;
	wire  [3:0][7:0] spr_v;
	wire  [3:0][7:0] count_v;
	wire  [7:0]      prio_v;

	wire       setup_ph   = psel_i && !penable_i;
	wire       access_wr  = psel_i && penable_i && pwrite_i;
	wire [5:0] reg_idx    = paddr_i[7:2];
	wire [5:0] ch_rel     = reg_idx - `IDX_CHANNEL_BASE;
	wire       ch_space   = (reg_idx >= `IDX_CHANNEL_BASE) &&
	                        (reg_idx < 6'(`IDX_CHANNEL_BASE + 4 * `IDX_CHANNEL_STRIDE));
	wire [1:0] ch_sel     = ch_rel[3:2];
	wire [1:0] ch_sub     = ch_rel[1:0];
	wire       hit_global = reg_idx == `IDX_GLOBAL_CONFIG_STATUS;
	wire       hit_sum    = reg_idx == `IDX_GLOBAL_IRQ_SUMMARY;
	wire       hit_ch     = ch_space && (ch_sub <= `SUB_CHANNEL_COUNT);
	wire       mapped     = hit_global || hit_sum || hit_ch;
	wire       global_active = |busy_v;
	wire       any_elig   = |eligible_v;
	wire       moving     = state == dma_ctrl_pkg::ST_MOVE;
	wire       item_done  = moving && bus_grant_i;
	wire       wait_over  = wait_cnt >= idle_wait_cycles;

	// The slave never stretches a transfer: every register is a plain flip-flop, so the
	// access phase always completes in its first cycle. Read data is captured one edge
	// earlier, in the setup cycle, which keeps the read path registered at the cost of
	// not seeing a flag that sets during the access cycle itself.

	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign prdata_o  = rdata;
	assign prio_v    = {spr_v[3][5:4], spr_v[2][5:4], spr_v[1][5:4], spr_v[0][5:4]};

	// A channel with very high priority outranks the CPU at once; others wait out the idle time.
	assign bus_req_o       = moving;
	assign bus_high_prio_o = moving &&
	                         (wait_over || (prio_v[2*cur +: 2] == `PRIO_VERY_HIGH));
	assign item_done_o     = item_done;

	// Wake-up follows the enabled flags only; it is a level, so the core sees it until
	// software clears the flag that caused it.
	// Wake-up is suppressed in halt modes; transfers go on there, as the engine ignores halt_mode_i.
	assign wake_req_o = (|channel_irq_o) && wait_mode_i && !halt_mode_i;

	// One slice per channel. Each slice keeps its configuration, priority, width,
	// flags, waiting request and counts, and reports them to the shared read mux and
	// arbiter through the packed vectors above.
	// A channel counts as on only while both the global and its own enable are set;
	// its configuration, priority and width are frozen while it is on or busy, so that
	// an item in flight never sees its qualifiers change underneath it.
	// The remaining count is frozen by the on state alone, which lets software reload
	// it between transactions without first waiting for the engine to go idle.

	generate
		for (genvar c = 0; c < 4; c++) begin : gen_ch
			logic [7:0] cfg;
			logic [1:0] prio;
			logic       wide;
			logic       half_done_flag;
			logic       all_done_flag;
			logic       request_waiting;
			logic [7:0] remaining_count;
			logic [7:0] programmed;

			wire on        = global_on && cfg[`CFG_EN_BIT];
			wire mem       = (c == `MEM_CHANNEL) && cfg[`CFG_MEM_BIT];
			wire busy      = moving && (cur == 2'(c));
			wire locked    = on || busy;
			wire sel       = hit_ch && (ch_sel == 2'(c));
			wire wr_cfg    = access_wr && sel && (ch_sub == `SUB_CHANNEL_CONFIG);
			wire wr_spr    = access_wr && sel && (ch_sub == `SUB_CHANNEL_STATUS);
			wire wr_cnt    = access_wr && sel && (ch_sub == `SUB_CHANNEL_COUNT);
			wire done_here = item_done && (cur == 2'(c));
			wire [7:0] cnt_dec  = remaining_count - 8'h01;
			wire       last     = done_here && (cnt_dec == 8'h00);
			wire       reload   = cfg[`CFG_WRAP_BIT] && !mem;
			wire       set_half = done_here && (cnt_dec == {1'b0, programmed[7:1]});
			wire       clr_half = wr_spr && !pwdata_i[`SPR_HALF_DONE_BIT];
			wire       clr_all  = wr_spr && !pwdata_i[`SPR_ALL_DONE_BIT];
			wire [7:0] cfg_mask = (c == `MEM_CHANNEL) ? 8'h7f : 8'h3f;

			always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					cfg  <= `CFG_RESET;
					prio <= 2'h0;
					wide <= 1'b0;
				end else if (wr_cfg && !locked) begin
					cfg <= pwdata_i[7:0] & cfg_mask;
				end else if (wr_spr && !locked) begin
					prio <= pwdata_i[`SPR_PRIO_MSB:`SPR_PRIO_LSB];
					wide <= pwdata_i[`SPR_WIDE_BIT];
				end
			end

			// The flags are sticky: once set they stay until software writes a 0 to
			// them, even while the channel keeps running. Writing a 1 has no effect, so
			// a read-modify-write of the status register cannot clear a flag by chance.
			// A limitation: a flag event that coincides with the clear is lost, and
			// software must look at the count if it cannot afford to miss one.
			// Clear wins over a same-cycle set, as the flag semantics demand.
			always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					half_done_flag <= 1'b0;
					all_done_flag  <= 1'b0;
				end else begin
					half_done_flag <= clr_half ? 1'b0 : (half_done_flag || set_half);
					all_done_flag  <= clr_all ? 1'b0 : (all_done_flag || last);
				end
			end

			// Requests at zero count are dropped; memory mode needs no request.
			always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					request_waiting <= 1'b0;
				end else if (!on || mem || done_here) begin
					request_waiting <= 1'b0;
				end else if (periph_req_i[c] && (remaining_count != 8'h00)) begin
					request_waiting <= 1'b1;
				end
			end

			// The programmed value is kept apart from the running count so that a wrap
			// reload and the half point both refer to what software last wrote.
			// Reaching zero never clears the enable bit.
			always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					remaining_count <= `COUNT_RESET;
					programmed      <= `COUNT_RESET;
				end else if (wr_cnt && !on) begin
					remaining_count <= pwdata_i[7:0];
					programmed      <= pwdata_i[7:0];
				end else if (done_here) begin
					remaining_count <= (last && reload) ? programmed : cnt_dec;
				end
			end

			assign busy_v[c]     = busy;
			assign eligible_v[c] = on && (remaining_count != 8'h00) &&
			                       (request_waiting || mem);
			assign flag_any_v[c] = half_done_flag || all_done_flag;
			assign cfg_v[c]      = cfg;
			assign spr_v[c]      = {busy, request_waiting && !mem, prio, wide,
			                        half_done_flag, all_done_flag, 1'b0};
			assign count_v[c]    = remaining_count;
			assign channel_irq_o[c] = (half_done_flag && cfg[`CFG_HALF_DONE_IE_BIT]) ||
			                          (all_done_flag && cfg[`CFG_ALL_DONE_IE_BIT]);
		end
	endgenerate

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			global_on        <= global_on_reset;
			idle_wait_cycles <= idle_wait_reset;
		end else if (access_wr && hit_global) begin
			global_on <= pwdata_i[`GCS_ON_BIT];
			if (!(global_on && global_active)) begin
				idle_wait_cycles <= pwdata_i[`GCS_WAIT_MSB:`GCS_WAIT_LSB];
			end
		end
	end

	// The idle wait field tells how long the engine stays polite to the core after an
	// item. Until the counter reaches the field, the request goes out at normal priority;
	// after that it is raised to high priority. A field of zero makes every request
	// high priority at once. The counter saturates at the field instead of wrapping, so
	// a long pause never brings back the polite phase.
	// The idle counter restarts whenever a request is served.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wait_cnt <= 6'h00;
		end else if (item_done) begin
			wait_cnt <= 6'h00;
		end else if (!wait_over) begin
			wait_cnt <= wait_cnt + 6'h01;
		end
	end

	// The engine is a two-state loop. In the idle state it picks the best eligible
	// channel and latches its qualifiers; in the move state it holds the bus request
	// until the arbiter grants one cycle. Returning to idle after every item costs one
	// cycle per item but lets a higher-priority channel take over between items, which
	// keeps a long low-priority transaction from starving the others.
	// One item is moved per grant; the engine then returns to arbitration.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= dma_ctrl_pkg::ST_IDLE;
			cur   <= 2'h0;
		end else begin
			case (state)
				dma_ctrl_pkg::ST_IDLE: begin
					if (any_elig) begin
						state <= dma_ctrl_pkg::ST_MOVE;
						cur   <= pick_channel(eligible_v, prio_v);
					end
				end
				dma_ctrl_pkg::ST_MOVE: begin
					if (bus_grant_i) begin
						state <= dma_ctrl_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= dma_ctrl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Configuration of the channel that the arbiter would pick in this cycle; used
	// only at the selection edge, when the engine is idle.
	wire [7:0] pick_cfg = cfg_v[pick_channel(eligible_v, prio_v)];
	wire [7:0] pick_spr = spr_v[pick_channel(eligible_v, prio_v)];
	wire       pick_mem = pick_cfg[`CFG_MEM_BIT];

	// Transfer qualifiers are latched at channel selection and hold through the item.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			xfer_channel_o    <= 2'h0;
			xfer_to_periph_o  <= 1'b0;
			xfer_mem_to_mem_o <= 1'b0;
			xfer_wide_o       <= 1'b0;
			mem0_step_up_o    <= 1'b0;
			mem1_step_up_o    <= 1'b0;
		end else if (!moving && any_elig) begin
			xfer_channel_o    <= pick_channel(eligible_v, prio_v);
			xfer_to_periph_o  <= pick_cfg[`CFG_DIR_BIT] && !pick_mem;
			xfer_mem_to_mem_o <= pick_mem;
			xfer_wide_o       <= pick_spr[`SPR_WIDE_BIT];
			mem0_step_up_o    <= pick_mem || pick_cfg[`CFG_STEP_UP_BIT];
			mem1_step_up_o    <= pick_cfg[`CFG_STEP_UP_BIT];
		end
	end

	// Read mux. Reserved bits and unmapped indices read as zero; the status register
	// hides the waiting bit in memory mode because no request is ever taken there.
	// The global active bit is computed, never stored, so it cannot disagree with the
	// busy bits of the channels.

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit_global) begin
			next_rdata[7:0] = {idle_wait_cycles, global_active, global_on};
		end else if (hit_sum) begin
			next_rdata[3:0] = flag_any_v;
		end else if (hit_ch) begin
			case (ch_sub)
				`SUB_CHANNEL_CONFIG: next_rdata[7:0] = cfg_v[ch_sel];
				`SUB_CHANNEL_STATUS: next_rdata[7:0] = spr_v[ch_sel];
				default:             next_rdata[7:0] = count_v[ch_sel];
			endcase
		end
	end

	// Read data is sampled in the setup cycle so that it comes from a flip-flop.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata <= 32'h0000_0000;
		end else if (setup_ph && !pwrite_i) begin
			rdata <= next_rdata;
		end
	end

endmodule : dma_channel_control_status
`default_nettype wire

// ---- dma_ctrl_monitor.sv ----
// Port-level checks for the DMA control block.
// Assumes it is bound onto dma_channel_control_status with one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl_monitor (
	input wire logic        clk_sys_i,
	input wire logic        rst_b_i,
	input wire logic [31:0] prdata_o,
	input wire logic        bus_grant_i,
	input wire logic        wait_mode_i,
	input wire logic        halt_mode_i,
	input wire logic        bus_req_o,
	input wire logic        bus_high_prio_o,
	input wire logic        item_done_o,
	input wire logic [1:0]  xfer_channel_o,
	input wire logic        xfer_wide_o,
	input wire logic        xfer_mem_to_mem_o,
	input wire logic        mem0_step_up_o,
	input wire logic [3:0]  channel_irq_o,
	input wire logic        wake_req_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_wait; bus_req_o && !bus_grant_i; endsequence
	sequence s_move; bus_req_o && bus_grant_i; endsequence
	property p_wake; wake_req_o == (|channel_irq_o && wait_mode_i && !halt_mode_i); endproperty
	a_wake: assert property (p_wake) else $error("wake request mismatch");
	property p_halt; halt_mode_i |-> !wake_req_o; endproperty
	a_halt: assert property (p_halt) else $error("wake during halt");
	property p_hold; s_wait |=> bus_req_o && $stable(xfer_channel_o) && $stable(xfer_wide_o); endproperty
	a_hold: assert property (p_hold) else $error("item changed before grant");
	property p_gap; s_move |-> item_done_o ##1 !bus_req_o; endproperty
	a_gap: assert property (p_gap) else $error("item not closed");
	property p_src; xfer_mem_to_mem_o && bus_req_o |-> mem0_step_up_o; endproperty
	a_src: assert property (p_src) else $error("source pointer steps down");
	property p_mem; xfer_mem_to_mem_o && bus_req_o |-> xfer_channel_o == 2'h3; endproperty
	a_mem: assert property (p_mem) else $error("memory mode on wrong channel");
	property p_prio; bus_high_prio_o |-> bus_req_o; endproperty
	a_prio: assert property (p_prio) else $error("high priority without request");
	property p_rsvd; prdata_o[31:8] == 24'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("upper read bits set");
endmodule : dma_ctrl_monitor
bind dma_channel_control_status dma_ctrl_monitor i_mon (.clk_sys_i, .rst_b_i, .prdata_o,
	.bus_grant_i, .wait_mode_i, .halt_mode_i, .bus_req_o, .bus_high_prio_o, .item_done_o,
	.xfer_channel_o, .xfer_wide_o, .xfer_mem_to_mem_o, .mem0_step_up_o, .channel_irq_o,
	.wake_req_o);
`default_nettype wire

// ---- dma_far_side_model.sv ----
// Peripheral request lines and bus arbiter facing the DMA block.
// Assumes the bench sets the grant delay only while no item is waiting.
`timescale 1ns/1ps
`default_nettype none
module dma_far_side_model (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_b_i,
	input  wire logic       bus_req_i,
	input  wire logic [1:0] grant_delay_i,
	input  wire logic [3:0] fire_i,
	output logic      [3:0] periph_req_o,
	output logic            bus_grant_o
);
	logic [1:0] waited;
	assign periph_req_o = fire_i;
	// A slow arbiter holds off the grant so the request must stand meanwhile.
	assign bus_grant_o = bus_req_i && (waited == grant_delay_i);
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i)
			waited <= 2'h0;
		else if (!bus_req_i || bus_grant_o)
			waited <= 2'h0;
		else
			waited <= waited + 2'h1;
	end
endmodule : dma_far_side_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the DMA control block over APB.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, q;
	logic pready_o, pslverr_o, bus_grant_i, bus_req_o, bus_high_prio_o, item_done_o, e;
	logic wait_mode_i = 1'b0, halt_mode_i = 1'b0, xfer_to_periph_o, xfer_mem_to_mem_o;
	logic xfer_wide_o, mem0_step_up_o, mem1_step_up_o, wake_req_o;
	logic [3:0] periph_req_i, channel_irq_o, fire = 4'h0;
	logic [1:0] xfer_channel_o, delay = 2'h0;
	int fails = 0, compares = 0, cyc = 0;
	always #2 clk_sys_i = ~clk_sys_i;
	dma_channel_control_status i_dut (.clk_sys_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .periph_req_i, .bus_grant_i,
		.wait_mode_i, .halt_mode_i, .bus_req_o, .bus_high_prio_o, .item_done_o, .xfer_channel_o,
		.xfer_to_periph_o, .xfer_mem_to_mem_o, .xfer_wide_o, .mem0_step_up_o, .mem1_step_up_o,
		.channel_irq_o, .wake_req_o);
	dma_far_side_model i_far (.clk_sys_i, .rst_b_i, .bus_req_i(bus_req_o), .grant_delay_i(delay),
		.fire_i(fire), .periph_req_o(periph_req_i), .bus_grant_o(bus_grant_i));
	task automatic summarize;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= {24'h0, d};
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		@(posedge clk_sys_i);
		while (!pready_o) begin
			@(posedge clk_sys_i);
		end
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 8'h00);
		chk(q, exp);
	endtask : rc
	// Snapshot order: channel, to-periph, mem mode, wide, source step up, high priority.
	task automatic item(input logic [3:0] m, input logic [6:0] exp);
		int n = 0;
		@(posedge clk_sys_i);
		fire <= m;
		@(posedge clk_sys_i);
		fire <= 4'h0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (item_done_o !== 1'b1 && n < 60);
		chk({xfer_channel_o, xfer_to_periph_o, xfer_mem_to_mem_o, xfer_wide_o,
			mem0_step_up_o, bus_high_prio_o}, exp);
	endtask : item
	initial begin
		repeat (10) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		rc(8'h00, 32'hfc);
		rc(8'h04, 32'h0);
		rc(8'h14, 32'h0);
		rc(8'h1c, 32'h0);
		chk(e, 1'b1);
		apb(1'b1, 8'h10, 8'h7e);
		rc(8'h10, 32'h3e);
		apb(1'b1, 8'h40, 8'h7e);
		rc(8'h40, 32'h7e);
		apb(1'b1, 8'h40, 8'h00);
		$display("test 1 done");
		apb(1'b1, 8'h00, 8'h03);
		rc(8'h00, 32'h01);
		apb(1'b1, 8'h18, 8'h04);
		apb(1'b1, 8'h10, 8'h27);
		item(4'h1, 7'h03);
		item(4'h1, 7'h03);
		chk(mem1_step_up_o, 1'b1);
		rc(8'h14, 32'h04);
		rc(8'h18, 32'h02);
		item(4'h1, 7'h03);
		item(4'h1, 7'h03);
		rc(8'h14, 32'h06);
		rc(8'h04, 32'h01);
		rc(8'h10, 32'h27);
		apb(1'b1, 8'h14, 8'h36);
		rc(8'h14, 32'h06);
		apb(1'b1, 8'h18, 8'h09);
		rc(8'h18, 32'h0);
		fire <= 4'h1;
		repeat (8) @(posedge clk_sys_i);
		fire <= 4'h0;
		rc(8'h18, 32'h0);
		wait_mode_i <= 1'b1;
		@(negedge clk_sys_i);
		chk(channel_irq_o, 4'h1);
		chk(wake_req_o, 1'b1);
		halt_mode_i <= 1'b1;
		@(negedge clk_sys_i);
		chk(wake_req_o, 1'b0);
		apb(1'b1, 8'h14, 8'h00);
		rc(8'h14, 32'h0);
		rc(8'h04, 32'h0);
		$display("test 2 done");
		apb(1'b1, 8'h24, 8'h38);
		rc(8'h24, 32'h38);
		apb(1'b1, 8'h28, 8'h01);
		apb(1'b1, 8'h20, 8'h0b);
		item(4'h2, 7'h35);
		rc(8'h24, 32'h3e);
		apb(1'b1, 8'h00, 8'hfd);
		delay <= 2'h3;
		apb(1'b1, 8'h38, 8'h02);
		apb(1'b1, 8'h30, 8'h11);
		item(4'h4, 7'h40);
		item(4'h4, 7'h40);
		rc(8'h38, 32'h02);
		apb(1'b1, 8'h00, 8'h00);
		apb(1'b1, 8'h10, 8'h00);
		rc(8'h10, 32'h00);
		$display("test 3 done");
		apb(1'b1, 8'h00, 8'hfd);
		apb(1'b1, 8'h48, 8'h01);
		apb(1'b1, 8'h40, 8'h51);
		item(4'h0, 7'h6a);
		chk(mem1_step_up_o, 1'b0);
		rc(8'h48, 32'h0);
		$display("test 4 done");
		summarize();
	end
endmodule : testbench
`default_nettype wire
